// ==== rtl/tss_pkg.sv ====
// Purpose: Shared constants for the touch sense setup command block
// Assumes: 200 MHz system clock, APB with 32-bit data
// Notes:   Setup tables hold sixteen ascending byte entries, entry 0 lowest
package tss_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_SCOPE  = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_GLOBAL = 8'h10;
  // Field positions
  localparam int CMD_CODE_LSB  = 0;
  localparam int CMD_SET_LSB   = 8;
  localparam int CMD_GET_BIT   = 16;
  localparam int SCOPE_IDX_LSB = 8;
  localparam int RES_VALID_BIT = 8;
  localparam int RES_ERR_BIT   = 9;
  localparam int GL_POSH_LSB   = 2;
  localparam int GL_SPC_LSB    = 4;
  // Command codes
  localparam logic [7:0] CMD_POS_THR   = 8'h02;
  localparam logic [7:0] CMD_NEG_HYST  = 8'h03;
  localparam logic [7:0] CMD_POS_HYST  = 8'h04;
  localparam logic [7:0] CMD_DWELL     = 8'h05;
  localparam logic [7:0] CMD_BURST     = 8'h06;
  localparam logic [7:0] CMD_SPACING   = 8'h07;
  localparam logic [7:0] CMD_NEG_DRIFT = 8'h08;
  localparam logic [7:0] CMD_POS_DRIFT = 8'h09;
  localparam logic [7:0] CMD_INTEG     = 8'h0a;
  localparam logic [7:0] DWELL_VALUE   = 8'h01;
  // Hysteresis and spacing codes
  localparam logic [1:0] HYST_NONE = 2'h3;
  localparam logic [2:0] SPC_MAX   = 3'h5;
  // Reset values of setup memory; fixed negative threshold
  localparam logic [7:0] DEF_POS_THR   = 8'h0a;
  localparam logic [7:0] DEF_BURST     = 8'h0a;
  localparam logic [7:0] DEF_NEG_DRIFT = 8'h14;
  localparam logic [7:0] DEF_POS_DRIFT = 8'h05;
  localparam logic [7:0] DEF_INTEG     = 8'h02;
  localparam logic [1:0] DEF_HYST      = 2'h1;
  localparam logic [2:0] DEF_SPC       = 3'h3;
  localparam logic [7:0] NEG_THR       = 8'h0a;
  // Quantizer tables
  localparam logic [127:0] TBL_POS_THR = {8'h40, 8'h37, 8'h2d, 8'h23,
    8'h1e, 8'h19, 8'h14, 8'h11, 8'h0f, 8'h0c, 8'h0a, 8'h08, 8'h07,
    8'h06, 8'h05, 8'h04};
  localparam logic [127:0] TBL_BURST = {8'h40, 8'h32, 8'h28, 8'h1e,
    8'h19, 8'h14, 8'h0f, 8'h0c, 8'h0a, 8'h07, 8'h05, 8'h04, 8'h03,
    8'h02, 8'h01, 8'h00};
  localparam logic [127:0] TBL_DRIFT = {8'h64, 8'h4b, 8'h3c, 8'h2d,
    8'h21, 8'h19, 8'h14, 8'h0f, 8'h0c, 8'h0a, 8'h08, 8'h06, 8'h04,
    8'h03, 8'h02, 8'h01};
  // Timing
  localparam int CLK_MHZ    = 200;
  localparam int DWELL_NS   = 167;
  localparam int DWELL_CYC  = (DWELL_NS * CLK_MHZ) / 1000;
  localparam int SPACE_US_0 = 250;
  localparam int SPACE_US_1 = 300;
  localparam int SPACE_US_2 = 400;
  localparam int SPACE_US_3 = 500;
  localparam int SPACE_US_4 = 1000;
  localparam int SPACE_US_5 = 2000;
  localparam int NUM_KEYS   = 64;
  localparam logic [5:0] LAST_SLOT = 6'h3f;
  // Scope modes
  typedef enum logic [1:0] {
    SCOPE_KEY = 2'h0,
    SCOPE_ROW = 2'h1,
    SCOPE_COL = 2'h2,
    SCOPE_ALL = 2'h3
  } tss_scope_t;
  // Command engine states
  typedef enum logic [3:0] {
    ST_LOAD   = 4'b0001,
    ST_IDLE   = 4'b0010,
    ST_EXEC   = 4'b0100,
    ST_COMMIT = 4'b1000
  } tss_state_t;
endpackage

// ==== rtl/tss_quant_if.sv ====
// Purpose: Carries a raw setting to a quantizer and the result back
// Assumes: Combinational path, same clock domain
// Notes:   One instance per quantizer table
`timescale 1ns/1ps
interface tss_quant_if;
  logic [7:0] raw;
  logic [7:0] quant;
  modport user (output raw, input quant);
  modport unit (input raw, output quant);
endinterface

// ==== rtl/tss_quant.sv ====
// Purpose: Rounds a setting down to the nearest entry of a table
// Assumes: Table entries ascending, entry 0 in the low byte
// Notes:   Values under the lowest entry give the lowest entry
`timescale 1ns/1ps
module tss_quant
  import tss_pkg::*;
#(
  parameter logic [127:0] TABLE = TBL_POS_THR
)(
  // Setting in, quantized setting out
  tss_quant_if.unit q
);
  always_comb
  begin
    q.quant = TABLE[7:0];
    for (int i = 0; i < 16; i++)
    begin
      if (q.raw >= TABLE[i*8 +: 8])
      begin
        q.quant = TABLE[i*8 +: 8];
      end
    end
  end
endmodule // tss_quant

// ==== rtl/tss_setup_cmd.sv ====
// Purpose: Setup command engine, setup memory and scan timing
// Assumes: APB master on clk; sensing front end on clk; X drive async
// Notes:   Setup memory is flip-flops reset to defaults
//
// Operation
// - Positive threshold Put writes every scoped key
// - Positive threshold rounded down to table
// - Command 0x03 sets global negative hysteresis
// - Hysteresis level lies between threshold and reference
// - Global setups take one byte, return one
// - Command 0x04 sets global positive hysteresis
// - Dwell accepted, fixed, Get returns 0x01
// - Dwell lasts one machine cycle after X rise
// - Burst length per key, rounded down to table
// - Zero burst idles slot and flags error
// - Global burst spacing, codes above five saturate
// - Full scan always spans 64 slots
// - Negative drift rate per key, rounded down
// - Negative drift suspended beyond threshold and hysteresis
// - Per-key Put scopes; Get returns one byte
// - Positive drift rate, only above reference
// - Positive drift continues above positive threshold
// - Command 0x0A stores integrator limit per key
// - Echo command byte; setting applies after echo
// - Integrator limit zero disables key, burst stays
`timescale 1ns/1ps
module tss_setup_cmd
  import tss_pkg::*;
#(
  parameter int SPC_CYC_0 = SPACE_US_0 * CLK_MHZ,
  parameter int SPC_CYC_1 = SPACE_US_1 * CLK_MHZ,
  parameter int SPC_CYC_2 = SPACE_US_2 * CLK_MHZ,
  parameter int SPC_CYC_3 = SPACE_US_3 * CLK_MHZ,
  parameter int SPC_CYC_4 = SPACE_US_4 * CLK_MHZ,
  parameter int SPC_CYC_5 = SPACE_US_5 * CLK_MHZ
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Matrix drive timing
  input  wire logic        xDriveClk,
  output logic             yGate,
  // Scan slot outputs
  output logic [5:0]       slotKey,
  output logic             burstOn,
  output logic [7:0]       burstLen,
  output logic             burstErr,
  output logic             keyEnable,
  output logic [7:0]       integLimit,
  // Drift control
  input  wire logic [7:0]  sigLevel,
  input  wire logic [7:0]  refLevel,
  output logic             negDriftEn,
  output logic             posDriftEn,
  output logic             posRecal
);
  localparam int DWELL_A = DWELL_CYC;

  tss_state_t  state_reg;
  logic [7:0]  nvThr [NUM_KEYS];
  logic [7:0]  nvBurst [NUM_KEYS];
  logic [7:0]  nvNegDr [NUM_KEYS];
  logic [7:0]  nvPosDr [NUM_KEYS];
  logic [7:0]  nvInteg [NUM_KEYS];
  logic [7:0]  wkThr [NUM_KEYS];
  logic [7:0]  wkBurst [NUM_KEYS];
  logic [7:0]  wkInteg [NUM_KEYS];
  logic [1:0]  nvNegHyst_reg;
  logic [1:0]  nvPosHyst_reg;
  logic [2:0]  nvSpc_reg;
  logic [1:0]  negHyst_reg;
  logic [1:0]  posHyst_reg;
  logic [2:0]  spc_reg;
  logic [7:0]  cmdCode_reg;
  logic [7:0]  cmdSet_reg;
  logic        cmdGet_reg;
  tss_scope_t  scopeMode_reg;
  logic [5:0]  scopeIdx_reg;
  logic [7:0]  result_reg;
  logic        resValid_reg;
  logic        resErr_reg;
  logic        apbSetup;
  logic        apbWrite;
  logic        cmdAccept;
  logic [31:0] readMux;
  logic        mapped;
  logic        knownCmd;

  tss_quant_if qThr ();
  tss_quant_if qBurst ();
  tss_quant_if qDrift ();
  tss_quant #(.TABLE(TBL_POS_THR)) uQuantThr (.q(qThr));
  tss_quant #(.TABLE(TBL_BURST)) uQuantBurst (.q(qBurst));
  tss_quant #(.TABLE(TBL_DRIFT)) uQuantDrift (.q(qDrift));
  assign qThr.raw   = cmdSet_reg;
  assign qBurst.raw = cmdSet_reg;
  assign qDrift.raw = cmdSet_reg;

  // A rounded setting at or above the lowest table entry never exceeds what the host asked for
  quant_floor_a: assert property (@(posedge clk) disable iff (!rst_n)
    (qThr.raw >= TBL_POS_THR[7:0]) |-> (qThr.quant <= qThr.raw))
    else $error("Threshold not rounded down");

  function automatic logic keySel(input int k, input tss_scope_t m,
                                  input logic [5:0] idx);
    logic [5:0] kk;
    kk = 6'(k);
    case (m)
      SCOPE_KEY: keySel = (kk == idx);
      SCOPE_ROW: keySel = (kk[2:0] == idx[2:0]);
      SCOPE_COL: keySel = (kk[5:3] == idx[2:0]);
      default:   keySel = 1'b1;
    endcase
  endfunction

  // Distance from reference to hysteresis level, never past threshold
  function automatic logic [7:0] hystLevel(input logic [7:0] thr,
                                           input logic [1:0] code);
    case (code)
      2'h0:    hystLevel = thr - (thr >> 1);
      2'h1:    hystLevel = thr - (thr >> 2);
      2'h2:    hystLevel = thr - (thr >> 3);
      default: hystLevel = thr;
    endcase
  endfunction

  // APB decode; zero wait states, so setup phase prepares read data
  assign apbSetup  = psel && !penable;
  assign apbWrite  = psel && penable && pwrite;
  assign cmdAccept = apbWrite && (paddr == ADDR_CMD) &&
                     (state_reg == ST_IDLE);
  assign mapped    = (paddr == ADDR_CMD) || (paddr == ADDR_SCOPE) ||
                     (paddr == ADDR_RESULT) || (paddr == ADDR_STATUS) ||
                     (paddr == ADDR_GLOBAL);
  assign knownCmd  = (cmdCode_reg >= CMD_POS_THR) &&
                     (cmdCode_reg <= CMD_INTEG);

  always_comb
  begin
    readMux = 32'h0;
    case (paddr)
      ADDR_CMD:
      begin
        readMux[CMD_CODE_LSB +: 8] = cmdCode_reg;
        readMux[CMD_SET_LSB +: 8]  = cmdSet_reg;
        readMux[CMD_GET_BIT]       = cmdGet_reg;
      end
      ADDR_SCOPE:
      begin
        readMux[1:0]                = scopeMode_reg;
        readMux[SCOPE_IDX_LSB +: 6] = scopeIdx_reg;
      end
      ADDR_RESULT:
      begin
        readMux[7:0]           = result_reg;
        readMux[RES_VALID_BIT] = resValid_reg;
        readMux[RES_ERR_BIT]   = resErr_reg;
      end
      ADDR_STATUS: readMux[3:0] = state_reg;
      ADDR_GLOBAL:
      begin
        readMux[1:0]              = negHyst_reg;
        readMux[GL_POSH_LSB +: 2] = posHyst_reg;
        readMux[GL_SPC_LSB +: 3]  = spc_reg;
      end
      default: readMux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (apbSetup)
      begin
        prdata  <= readMux;
        pslverr <= !mapped;
      end
    end
  end

  // Command and scope registers; command writes while busy are dropped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmdCode_reg   <= 8'h0;
      cmdSet_reg    <= 8'h0;
      cmdGet_reg    <= 1'b0;
      scopeMode_reg <= SCOPE_KEY;
      scopeIdx_reg  <= 6'h0;
    end
    else
    begin
      if (cmdAccept)
      begin
        cmdCode_reg <= pwdata[CMD_CODE_LSB +: 8];
        cmdSet_reg  <= pwdata[CMD_SET_LSB +: 8];
        cmdGet_reg  <= pwdata[CMD_GET_BIT];
      end
      if (apbWrite && (paddr == ADDR_SCOPE))
      begin
        scopeMode_reg <= tss_scope_t'(pwdata[1:0]);
        scopeIdx_reg  <= pwdata[SCOPE_IDX_LSB +: 6];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_LOAD;
    end
    else
    begin
      case (state_reg)
        ST_LOAD:   state_reg <= ST_IDLE;
        ST_IDLE:   state_reg <= cmdAccept ? ST_EXEC : ST_IDLE;
        ST_EXEC:   state_reg <= ST_COMMIT;
        ST_COMMIT: state_reg <= ST_IDLE;
        default:   state_reg <= ST_IDLE;
      endcase
    end
  end

  // Result byte: echo on Put, stored value on Get
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_reg   <= 8'h0;
      resValid_reg <= 1'b0;
      resErr_reg   <= 1'b0;
    end
    else if (cmdAccept)
    begin
      resValid_reg <= 1'b0;
    end
    else if (state_reg == ST_EXEC)
    begin
      resValid_reg <= 1'b1;
      resErr_reg   <= !knownCmd;
      if (!cmdGet_reg)
      begin
        result_reg <= cmdCode_reg;
      end
      else
      begin
        case (cmdCode_reg)
          CMD_POS_THR:   result_reg <= nvThr[scopeIdx_reg];
          CMD_NEG_HYST:  result_reg <= {6'h0, nvNegHyst_reg};
          CMD_POS_HYST:  result_reg <= {6'h0, nvPosHyst_reg};
          CMD_DWELL:     result_reg <= DWELL_VALUE;
          CMD_BURST:     result_reg <= nvBurst[scopeIdx_reg];
          CMD_SPACING:   result_reg <= {5'h0, nvSpc_reg};
          CMD_NEG_DRIFT: result_reg <= nvNegDr[scopeIdx_reg];
          CMD_POS_DRIFT: result_reg <= nvPosDr[scopeIdx_reg];
          CMD_INTEG:     result_reg <= nvInteg[scopeIdx_reg];
          default:       result_reg <= 8'h0;
        endcase
      end
    end
  end

  // Setup memory; global settings ignore scope
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nvNegHyst_reg <= DEF_HYST;
      nvPosHyst_reg <= DEF_HYST;
      nvSpc_reg     <= DEF_SPC;
      for (int k = 0; k < NUM_KEYS; k++)
      begin
        nvThr[k]   <= DEF_POS_THR;
        nvBurst[k] <= DEF_BURST;
        nvNegDr[k] <= DEF_NEG_DRIFT;
        nvPosDr[k] <= DEF_POS_DRIFT;
        nvInteg[k] <= DEF_INTEG;
      end
    end
    else if ((state_reg == ST_EXEC) && !cmdGet_reg)
    begin
      if (cmdCode_reg == CMD_NEG_HYST)
        nvNegHyst_reg <= (cmdSet_reg > {6'h0, HYST_NONE}) ? HYST_NONE :
                         cmdSet_reg[1:0];
      if (cmdCode_reg == CMD_POS_HYST)
        nvPosHyst_reg <= (cmdSet_reg > {6'h0, HYST_NONE}) ? HYST_NONE :
                         cmdSet_reg[1:0];
      if (cmdCode_reg == CMD_SPACING)
        nvSpc_reg <= (cmdSet_reg > {5'h0, SPC_MAX}) ? SPC_MAX :
                     cmdSet_reg[2:0];
      for (int k = 0; k < NUM_KEYS; k++)
      begin
        if (keySel(k, scopeMode_reg, scopeIdx_reg))
        begin
          if (cmdCode_reg == CMD_POS_THR)
            nvThr[k] <= qThr.quant;
          if (cmdCode_reg == CMD_BURST)
            nvBurst[k] <= qBurst.quant;
          if (cmdCode_reg == CMD_NEG_DRIFT)
            nvNegDr[k] <= qDrift.quant;
          if (cmdCode_reg == CMD_POS_DRIFT)
            nvPosDr[k] <= qDrift.quant;
          if (cmdCode_reg == CMD_INTEG)
            nvInteg[k] <= cmdSet_reg;
        end
      end
    end
  end

  // Working set follows setup memory at start and after each echo
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      negHyst_reg <= DEF_HYST;
      posHyst_reg <= DEF_HYST;
      spc_reg     <= DEF_SPC;
      for (int k = 0; k < NUM_KEYS; k++)
      begin
        wkThr[k]   <= DEF_POS_THR;
        wkBurst[k] <= DEF_BURST;
        wkInteg[k] <= DEF_INTEG;
      end
    end
    else if ((state_reg == ST_LOAD) || (state_reg == ST_COMMIT))
    begin
      negHyst_reg <= nvNegHyst_reg;
      posHyst_reg <= nvPosHyst_reg;
      spc_reg     <= nvSpc_reg;
      for (int k = 0; k < NUM_KEYS; k++)
      begin
        wkThr[k]   <= nvThr[k];
        wkBurst[k] <= nvBurst[k];
        wkInteg[k] <= nvInteg[k];
      end
    end
  end

  // Dwell gate; X drive is asynchronous so it is synchronised first
  logic       xSync1;
  logic       xSync2;
  logic       xSync3;
  logic       xRise;
  logic [7:0] dwellCnt;
  assign xRise = xSync2 && !xSync3;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xSync1   <= 1'b0;
      xSync2   <= 1'b0;
      xSync3   <= 1'b0;
      dwellCnt <= 8'h0;
      yGate    <= 1'b0;
    end
    else
    begin
      xSync1 <= xDriveClk;
      xSync2 <= xSync1;
      xSync3 <= xSync2;
      if (xRise)
      begin
        dwellCnt <= 8'(DWELL_CYC);
        yGate    <= 1'b1;
      end
      else if (dwellCnt != 8'h0)
      begin
        dwellCnt <= dwellCnt - 8'h1;
        yGate    <= (dwellCnt > 8'h1);
      end
    end
  end

  // Scan slot timer; zero-burst slots keep their time but stay idle
  logic [19:0] spcCnt;
  logic [19:0] spcLoad;
  always_comb
  begin
    case (spc_reg)
      3'h0:    spcLoad = 20'(SPC_CYC_0 - 1);
      3'h1:    spcLoad = 20'(SPC_CYC_1 - 1);
      3'h2:    spcLoad = 20'(SPC_CYC_2 - 1);
      3'h3:    spcLoad = 20'(SPC_CYC_3 - 1);
      3'h4:    spcLoad = 20'(SPC_CYC_4 - 1);
      default: spcLoad = 20'(SPC_CYC_5 - 1);
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spcCnt     <= 20'h0;
      slotKey    <= 6'h0;
      burstOn    <= 1'b0;
      burstLen   <= 8'h0;
      burstErr   <= 1'b0;
      keyEnable  <= 1'b0;
      integLimit <= 8'h0;
    end
    else
    begin
      if (spcCnt == 20'h0)
      begin
        spcCnt  <= spcLoad;
        slotKey <= slotKey + 6'h1;
      end
      else
      begin
        spcCnt <= spcCnt - 20'h1;
      end
      burstLen   <= wkBurst[slotKey];
      burstOn    <= (wkBurst[slotKey] != 8'h0);
      burstErr   <= (wkBurst[slotKey] == 8'h0);
      keyEnable  <= (wkInteg[slotKey] != 8'h0);
      integLimit <= wkInteg[slotKey];
    end
  end

  // Drift gating for the key in the current slot
  logic [63:0] negSusp;
  logic [63:0] posDet;
  logic [7:0]  negDelta;
  logic [7:0]  posDelta;
  logic        negSuspNext;
  assign negDelta = (sigLevel < refLevel) ? refLevel - sigLevel : 8'h0;
  assign posDelta = (sigLevel > refLevel) ? sigLevel - refLevel : 8'h0;
  assign negSuspNext = (negDelta >= NEG_THR) ||
    (negSusp[slotKey] && (negDelta >= hystLevel(NEG_THR, negHyst_reg)));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      negSusp    <= 64'h0;
      posDet     <= 64'h0;
      negDriftEn <= 1'b0;
      posDriftEn <= 1'b0;
      posRecal   <= 1'b0;
    end
    else
    begin
      negSusp[slotKey] <= negSuspNext;
      negDriftEn       <= (negDelta != 8'h0) && !negSuspNext;
      posDriftEn       <= (posDelta != 8'h0);
      posDet[slotKey]  <= (posDelta >= wkThr[slotKey]) ||
        (posDet[slotKey] &&
         (posDelta >= hystLevel(wkThr[slotKey], posHyst_reg)));
      posRecal <= (posDelta >= wkThr[slotKey]) ||
        (posDet[slotKey] &&
         (posDelta >= hystLevel(wkThr[slotKey], posHyst_reg)));
    end
  end

  echo_put_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_EXEC) && !cmdGet_reg |=>
      resValid_reg && (result_reg == $past(cmdCode_reg)))
    else $error("Put not echoed");
  dwell_get_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_EXEC) && cmdGet_reg && (cmdCode_reg == CMD_DWELL)
      |=> (result_reg == DWELL_VALUE))
    else $error("Dwell get not 0x01");
  hyst_sat_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_EXEC) && !cmdGet_reg &&
    (cmdCode_reg == CMD_POS_HYST) && (cmdSet_reg > {6'h0, HYST_NONE})
      |=> (nvPosHyst_reg == HYST_NONE) ##1 (posHyst_reg == HYST_NONE))
    else $error("Hysteresis not saturated or applied");
  spc_sat_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_EXEC) && !cmdGet_reg &&
    (cmdCode_reg == CMD_SPACING) && (cmdSet_reg > {5'h0, SPC_MAX})
      |=> (nvSpc_reg == SPC_MAX))
    else $error("Spacing not saturated");
  thr_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_EXEC) && !cmdGet_reg &&
    (cmdCode_reg == CMD_POS_THR) && (scopeMode_reg == SCOPE_ALL)
      |=> (nvThr[0] == $past(qThr.quant)) &&
          (nvThr[63] == $past(qThr.quant)))
    else $error("Threshold not stored to all keys");
  dwell_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    xRise |=> yGate && (dwellCnt == DWELL_A))
    else $error("Dwell gate not started");
  slot_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (spcCnt == 20'h0) && (slotKey == LAST_SLOT) |=> (slotKey == 6'h0))
    else $error("Scan slot did not wrap");
  zero_burst_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wkBurst[slotKey] == 8'h0) && $stable(slotKey) |=>
      !burstOn && burstErr)
    else $error("Zero burst not idle");
  neg_susp_a: assert property (@(posedge clk) disable iff (!rst_n)
    (negDelta >= NEG_THR) |=> !negDriftEn)
    else $error("Negative drift not suspended");
  pos_drift_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sigLevel > refLevel) |=> posDriftEn)
    else $error("Positive drift not applied");
  integ_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wkInteg[slotKey] == 8'h0) && (wkBurst[slotKey] != 8'h0) &&
    $stable(slotKey) |=> !keyEnable && burstOn)
    else $error("Disabled key lost its burst");
endmodule // tss_setup_cmd

// ==== testbench/tss_xdrive_model.sv ====
// Purpose: X drive source standing in for the matrix front end
// Assumes: 64 ns period while a frame is enabled
// Notes:   Rests low between frames, phase free of clk
`timescale 1ns/1ps
module tss_xdrive_model (
  // Frame control
  input  wire logic en,
  // X drive
  output logic      xDriveClk
);
  always #32 xDriveClk = en ? ~xDriveClk : 1'b0;
endmodule // tss_xdrive_model

// ==== testbench/touch_sense_setup_commands_test.sv ====
// Purpose: Self-checking bench for the setup command block
// Assumes: Bench is the APB master; slot times shortened
// Notes:   One task per scenario
`timescale 1ns/1ps
module touch_sense_setup_commands_test
  import tss_pkg::*;
();
  localparam int SPC5 = 160;
  logic        clk, rst_n, psel, penable, pwrite, xEn, errSeen;
  logic        pready, pslverr, xDriveClk, yGate, burstOn, burstErr;
  logic        keyEnable, negDriftEn, posDriftEn, posRecal;
  logic [7:0]  paddr, sigLevel, refLevel, burstLen, integLimit, res;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  slotKey;
  int          errors, checkCount, n;

  tss_setup_cmd #(.SPC_CYC_0(20), .SPC_CYC_1(24), .SPC_CYC_2(32),
    .SPC_CYC_3(40), .SPC_CYC_4(80), .SPC_CYC_5(SPC5)) dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xDriveClk(xDriveClk),
    .yGate(yGate), .slotKey(slotKey), .burstOn(burstOn),
    .burstLen(burstLen), .burstErr(burstErr), .keyEnable(keyEnable),
    .integLimit(integLimit), .sigLevel(sigLevel), .refLevel(refLevel),
    .negDriftEn(negDriftEn), .posDriftEn(posDriftEn), .posRecal(posRecal));
  tss_xdrive_model xdrv_u (.en(xEn), .xDriveClk(xDriveClk));

  always #2.5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic endOfTest();
    $display("errors %0d checks %0d", errors, checkCount);
    if (errors == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 64);
    if (k == 64)
    begin
      errors++;
      endOfTest();
    end
    rd = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Result is only fresh one edge after the command is taken
  task automatic cmd(input logic [7:0] c, s, input logic g);
    int k;
    k = 0;
    bus(1'b1, ADDR_CMD, {15'h0, g, s, c});
    repeat (2) @(posedge clk);
    do
    begin
      bus(1'b0, ADDR_RESULT, 32'h0);
      k++;
    end
    while (rd[RES_VALID_BIT] !== 1'b1 && k < 16);
    check(rd[RES_VALID_BIT], 1'b1);
    res = rd[7:0];
  endtask

  task automatic put(input logic [7:0] c, s, input logic [1:0] m,
                     input logic [5:0] idx);
    bus(1'b1, ADDR_SCOPE, {18'h0, idx, 6'h0, m});
    cmd(c, s, 1'b0);
    check(res, c);
  endtask

  task automatic get(input logic [7:0] c, input logic [5:0] idx,
                     input logic [7:0] exp);
    bus(1'b1, ADDR_SCOPE, {18'h0, idx, 8'h0});
    cmd(c, 8'h0, 1'b1);
    check(res, exp);
  endtask

  task automatic t_defaults();
    get(CMD_POS_THR, 6'h00, DEF_POS_THR);
    get(CMD_BURST, 6'h3f, DEF_BURST);
    get(CMD_NEG_DRIFT, 6'h01, DEF_NEG_DRIFT);
    get(CMD_POS_DRIFT, 6'h02, DEF_POS_DRIFT);
    get(CMD_INTEG, 6'h03, DEF_INTEG);
    bus(1'b0, ADDR_GLOBAL, 32'h0);
    check(rd[6:0], {DEF_SPC, DEF_HYST, DEF_HYST});
  endtask

  task automatic t_quant();
    put(CMD_POS_THR, 8'h09, SCOPE_ALL, 6'h00);
    get(CMD_POS_THR, 6'h3f, 8'h08);
    put(CMD_POS_THR, 8'h03, SCOPE_KEY, 6'h05);
    get(CMD_POS_THR, 6'h05, 8'h04);
    get(CMD_POS_THR, 6'h06, 8'h08);
    put(CMD_BURST, 8'h06, SCOPE_ALL, 6'h00);
    get(CMD_BURST, 6'h07, 8'h05);
    put(CMD_NEG_DRIFT, 8'h50, SCOPE_ALL, 6'h00);
    get(CMD_NEG_DRIFT, 6'h08, 8'h4b);
    put(CMD_POS_DRIFT, 8'h0b, SCOPE_ALL, 6'h00);
    get(CMD_POS_DRIFT, 6'h09, 8'h0a);
    put(CMD_INTEG, 8'h37, SCOPE_COL, 6'h01);
    get(CMD_INTEG, 6'h0c, 8'h37);
  endtask

  task automatic t_global();
    put(CMD_NEG_HYST, 8'h02, SCOPE_KEY, 6'h00);
    get(CMD_NEG_HYST, 6'h09, 8'h02);
    put(CMD_POS_HYST, 8'h07, SCOPE_KEY, 6'h00);
    get(CMD_POS_HYST, 6'h00, {6'h0, HYST_NONE});
    put(CMD_SPACING, 8'h09, SCOPE_ALL, 6'h00);
    get(CMD_SPACING, 6'h00, {5'h0, SPC_MAX});
    put(CMD_DWELL, 8'h07, SCOPE_ALL, 6'h00);
    get(CMD_DWELL, 6'h00, DWELL_VALUE);
    bus(1'b0, ADDR_GLOBAL, 32'h0);
    check(rd[6:0], 7'h5e);
    cmd(8'h01, 8'h00, 1'b0);
    check(rd[RES_ERR_BIT], 1'b1);
    bus(1'b0, 8'h14, 32'h0);
    check(errSeen, 1'b1);
    check(rd, 32'h0);
  endtask

  // X held still between frames so one rise gives one clean dwell
  task automatic t_dwell();
    xEn <= 1'b0;
    repeat (80) @(posedge clk);
    check(yGate, 1'b0);
    xEn <= 1'b1;
    n = 0;
    while (yGate !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    xEn <= 1'b0;
    n = 0;
    while (yGate === 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    check(n, DWELL_CYC);
  endtask

  task automatic t_slot();
    put(CMD_BURST, 8'h00, SCOPE_ROW, 6'h02);
    get(CMD_BURST, 6'h0b, 8'h05);
    put(CMD_INTEG, 8'h00, SCOPE_KEY, 6'h0b);
    n = 0;
    while (slotKey !== 6'h0a && n < 30000)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    check({slotKey, burstOn, burstErr, burstLen}, {6'h0a, 10'h100});
    while (slotKey !== 6'h0b && n < 30000)
    begin
      @(posedge clk);
      n++;
    end
    n = 1;
    @(posedge clk);
    check({slotKey, keyEnable, integLimit, burstOn}, {6'h0b, 10'h1});
    while (slotKey === 6'h0b && n < 30000)
    begin
      @(posedge clk);
      n++;
    end
    while (slotKey !== 6'h0b && n < 30000)
    begin
      @(posedge clk);
      n++;
    end
    check(n, 64 * SPC5);
  endtask

  // Run straight after a slot change so the key stays put
  task automatic t_drift();
    refLevel <= 8'h80;
    sigLevel <= 8'h60;
    repeat (3) @(posedge clk);
    check(negDriftEn, 1'b0);
    sigLevel <= 8'h77;
    repeat (3) @(posedge clk);
    check(negDriftEn, 1'b0);
    sigLevel <= 8'h7c;
    repeat (3) @(posedge clk);
    check(negDriftEn, 1'b1);
    sigLevel <= 8'h90;
    repeat (3) @(posedge clk);
    check({posDriftEn, posRecal}, 2'h3);
  endtask

  initial
  begin
    {clk, rst_n, psel, penable, pwrite, xEn} = '0;
    {paddr, sigLevel, refLevel, pwdata, errors, checkCount} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    xEn   <= 1'b1;
    t_defaults();
    t_quant();
    t_global();
    t_dwell();
    t_slot();
    t_drift();
    endOfTest();
  end
endmodule // touch_sense_setup_commands_test
